//--- design/c8dec_pkg.sv
package c8dec_pkg;
    // ------------------------------------------------------------
    // timing and encodings
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int MCYC_PERIOD_NS = 20;
    localparam int MCYC_CLKS = MCYC_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [2:0] MC_1 = 3'h1;
    localparam logic [2:0] MC_2 = 3'h2;
    localparam logic [2:0] MC_4 = 3'h4;
    localparam logic [3:0] EXT_SEL_STORE = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_GEN, OP_ADDC_R, OP_SUBB_R, OP_INC_DP, OP_ANL_DI, OP_RLC,
        OP_MOVC_DP, OP_MOVC_PC, OP_XRD_DP, OP_XWR_DP, OP_XRD_RI,
        OP_PUSH, OP_POP, OP_XCHD, OP_ANLC_N, OP_ORLC_N, OP_JBC,
        OP_JMP_ADP, OP_CJNE_R, OP_DJNZ_R, OP_AJMP, OP_ACALL,
        OP_MUL, OP_DIV, OP_MOVC_ST, OP_TRAP
    } c8dec_op_t;

    typedef struct packed {
        c8dec_op_t op;
        logic [1:0] len;
        logic [2:0] mcyc;
        logic [2:0] rn;
        logic ri;
    } c8dec_dec_t;

    // core state sampled at the start of execution
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] reg_val;
        logic [7:0] mem;
        logic [7:0] sp;
        logic cy;
        logic bit_val;
        logic [15:0] dptr;
        logic [15:0] pc;
    } c8dec_cpu_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] mem;
        logic [7:0] sp;
        logic cy;
        logic ov;
        logic branch;
        logic bit_clr;
        logic [15:0] addr;
        logic [15:0] dptr;
    } c8dec_res_t;
endpackage

//--- design/c8dec_mc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module c8dec_mc_timer #(
    parameter int MAX_MCYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [2:0] i_mcyc,
    output logic o_busy,
    output logic o_done
);
    // ------------------------------------------------------------
    // clock countdown
    // ------------------------------------------------------------
    if (MAX_MCYC < 1 || MAX_MCYC * c8dec_pkg::MCYC_CLKS > 15) begin : g_chk
        $error("c8dec_mc_timer: MAX_MCYC out of range");
    end

    logic [3:0] cnt_r;
    logic busy_r;
    wire logic [3:0] load_w;
    wire logic last_w;

    // machine cycles are counted as pairs of clocks
    assign load_w = 4'(i_mcyc * c8dec_pkg::MCYC_CLKS - 1);
    assign last_w = busy_r && (cnt_r == 4'h0);
    assign o_busy = busy_r;
    assign o_done = last_w;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
        end else if (i_start) begin
            cnt_r <= load_w;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
            busy_r <= !last_w;
        end
    end
endmodule
`default_nettype wire

//--- design/c8dec_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module c8dec_decoder (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_code_valid,
    input wire logic [7:0] i_code_byte,
    input wire logic [3:0] i_ext_opcode_sel,
    input wire c8dec_pkg::c8dec_cpu_t i_cpu,
    output logic o_code_ready,
    output c8dec_pkg::c8dec_dec_t o_dec,
    output logic [7:0] o_opnd1,
    output logic [7:0] o_opnd2,
    output logic o_exec_start,
    output logic o_busy,
    output logic o_done,
    output c8dec_pkg::c8dec_res_t o_res
);
    // ------------------------------------------------------------
    // opcode tables
    // ------------------------------------------------------------
    function automatic logic [1:0] len_f(input logic [7:0] o);
        logic [1:0] l;
        l = c8dec_pkg::LEN_1;
        casez (o)
            8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
            8'h75, 8'h85, 8'h90, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hD5,
            8'b1011_1???, 8'b1101_1???: l = c8dec_pkg::LEN_3;
            8'h?1, 8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55,
            8'h65, 8'h95, 8'hC5, 8'hE5, 8'hF5, 8'h24, 8'h34, 8'h44,
            8'h54, 8'h64, 8'h74, 8'h94, 8'h40, 8'h50, 8'h60, 8'h70,
            8'h80, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'h42, 8'h52, 8'h62,
            8'h72, 8'h82, 8'h92, 8'hA2, 8'hB2, 8'hC2, 8'hD2, 8'h76,
            8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7, 8'b0111_1???,
            8'b1000_1???, 8'b1010_1???: l = c8dec_pkg::LEN_2;
            default: l = c8dec_pkg::LEN_1;
        endcase
        return l;
    endfunction

    function automatic logic [2:0] mcyc_f(input logic [7:0] o,
                                          input logic st);
        logic [2:0] m;
        m = c8dec_pkg::MC_1;
        casez (o)
            8'h84, 8'hA4: m = c8dec_pkg::MC_4;
            8'hA3, 8'h43, 8'h53, 8'h63, 8'h?1, 8'h02, 8'h12,
            8'h22, 8'h32, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60,
            8'h70, 8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'hE0,
            8'hF0, 8'h72, 8'h82, 8'h92, 8'h73, 8'h83, 8'h93, 8'hB4,
            8'hB5, 8'hB6, 8'hB7, 8'b1011_1???, 8'hD5, 8'b1101_1???,
            8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'b1010_1???, 8'b1000_1???,
            8'h85, 8'h86, 8'h87, 8'h75, 8'hA6, 8'hA7:
                m = c8dec_pkg::MC_2;
            8'hA5: m = st ? c8dec_pkg::MC_2 : c8dec_pkg::MC_1;
            default: m = c8dec_pkg::MC_1;
        endcase
        return m;
    endfunction

    function automatic c8dec_pkg::c8dec_op_t op_f(input logic [7:0] o,
                                                  input logic st);
        c8dec_pkg::c8dec_op_t p;
        p = c8dec_pkg::OP_GEN;
        casez (o)
            8'b0011_1???: p = c8dec_pkg::OP_ADDC_R;
            8'b1001_1???: p = c8dec_pkg::OP_SUBB_R;
            8'b1011_1???: p = c8dec_pkg::OP_CJNE_R;
            8'b1101_1???: p = c8dec_pkg::OP_DJNZ_R;
            8'b???00001: p = c8dec_pkg::OP_AJMP;
            8'b???10001: p = c8dec_pkg::OP_ACALL;
            8'hA3: p = c8dec_pkg::OP_INC_DP;
            8'h53: p = c8dec_pkg::OP_ANL_DI;
            8'h33: p = c8dec_pkg::OP_RLC;
            8'h93: p = c8dec_pkg::OP_MOVC_DP;
            8'h83: p = c8dec_pkg::OP_MOVC_PC;
            8'hE0: p = c8dec_pkg::OP_XRD_DP;
            8'hF0: p = c8dec_pkg::OP_XWR_DP;
            8'hE2, 8'hE3: p = c8dec_pkg::OP_XRD_RI;
            8'hC0: p = c8dec_pkg::OP_PUSH;
            8'hD0: p = c8dec_pkg::OP_POP;
            8'hD6, 8'hD7: p = c8dec_pkg::OP_XCHD;
            8'hB0: p = c8dec_pkg::OP_ANLC_N;
            8'hA0: p = c8dec_pkg::OP_ORLC_N;
            8'h10: p = c8dec_pkg::OP_JBC;
            8'h73: p = c8dec_pkg::OP_JMP_ADP;
            8'hA4: p = c8dec_pkg::OP_MUL;
            8'h84: p = c8dec_pkg::OP_DIV;
            8'hA5: p = st ? c8dec_pkg::OP_MOVC_ST : c8dec_pkg::OP_TRAP;
            default: p = c8dec_pkg::OP_GEN;
        endcase
        return p;
    endfunction

    function automatic logic [15:0] rel_f(input logic [15:0] pc,
                                          input logic [1:0] len,
                                          input logic [7:0] rel);
        return 16'(pc + {14'h0, len} + {{8{rel[7]}}, rel});
    endfunction

    // ------------------------------------------------------------
    // fetch sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_EXEC} c8dec_st_t;

    c8dec_st_t st_r;
    c8dec_st_t st_nxt;
    c8dec_pkg::c8dec_dec_t dec_r;
    c8dec_pkg::c8dec_res_t res_r;
    c8dec_pkg::c8dec_res_t res_nxt;
    logic [7:0] op_r;
    logic [7:0] b1_r;
    logic [7:0] b2_r;
    logic [1:0] got_r;
    logic start_r;
    wire logic take_w;
    wire logic store_sel_w;
    wire logic fetched_w;
    wire logic tmr_done_w;
    wire logic tmr_busy_w;
    wire c8dec_pkg::c8dec_dec_t dec_w;

    // store versus trap is chosen by the extended select field
    assign store_sel_w = i_ext_opcode_sel == c8dec_pkg::EXT_SEL_STORE;
    assign dec_w.op = op_f(i_code_byte, store_sel_w);
    assign dec_w.len = len_f(i_code_byte);
    assign dec_w.mcyc = mcyc_f(i_code_byte, store_sel_w);
    assign dec_w.rn = i_code_byte[2:0];
    assign dec_w.ri = i_code_byte[0];
    assign o_code_ready = st_r != ST_EXEC;
    assign take_w = i_code_valid && o_code_ready;
    // the last operand byte completes the fetch
    assign fetched_w = take_w && (2'(got_r + 2'h1) == dec_r.len);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: begin
                if (take_w) begin
                    st_nxt = (dec_w.len == c8dec_pkg::LEN_1) ? ST_EXEC
                                                             : ST_OPND;
                end
            end
            ST_OPND: begin
                if (fetched_w) begin
                    st_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (tmr_done_w) begin
                    st_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            start_r <= (st_r != ST_EXEC) && (st_nxt == ST_EXEC);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dec_r <= '0;
            op_r <= c8dec_pkg::BYTE_RST;
            b1_r <= c8dec_pkg::BYTE_RST;
            b2_r <= c8dec_pkg::BYTE_RST;
            got_r <= 2'h0;
        end else if (take_w && st_r == ST_IDLE) begin
            dec_r <= dec_w;
            op_r <= i_code_byte;
            got_r <= 2'h1;
        end else if (take_w) begin
            if (got_r == 2'h1) begin
                b1_r <= i_code_byte;
            end else begin
                b2_r <= i_code_byte;
            end
            got_r <= 2'(got_r + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // execution results
    // ------------------------------------------------------------
    logic [8:0] sum_w;
    logic [15:0] prod_w;
    logic [15:0] pcn_w;

    always_comb begin
        sum_w = 9'h000;
        prod_w = {8'h00, i_cpu.acc} * {8'h00, i_cpu.b};
        pcn_w = 16'(i_cpu.pc + {14'h0, dec_r.len});
        res_nxt = '0;
        res_nxt.acc = i_cpu.acc;
        res_nxt.b = i_cpu.b;
        res_nxt.mem = i_cpu.mem;
        res_nxt.sp = i_cpu.sp;
        res_nxt.cy = i_cpu.cy;
        res_nxt.dptr = i_cpu.dptr;
        unique case (dec_r.op)
            c8dec_pkg::OP_ADDC_R: begin
                sum_w = {1'b0, i_cpu.acc} + {1'b0, i_cpu.reg_val}
                        + {8'h00, i_cpu.cy};
                res_nxt.acc = sum_w[7:0];
                res_nxt.cy = sum_w[8];
                res_nxt.ov = (i_cpu.acc[7] == i_cpu.reg_val[7])
                             && (sum_w[7] != i_cpu.acc[7]);
            end
            c8dec_pkg::OP_SUBB_R: begin
                sum_w = {1'b0, i_cpu.acc} - {1'b0, i_cpu.reg_val}
                        - {8'h00, i_cpu.cy};
                res_nxt.acc = sum_w[7:0];
                res_nxt.cy = sum_w[8];
                res_nxt.ov = (i_cpu.acc[7] != i_cpu.reg_val[7])
                             && (sum_w[7] != i_cpu.acc[7]);
            end
            c8dec_pkg::OP_INC_DP: res_nxt.dptr = 16'(i_cpu.dptr + 16'h1);
            c8dec_pkg::OP_ANL_DI: begin
                res_nxt.addr = {8'h00, b1_r};
                res_nxt.mem = i_cpu.mem & b2_r;
            end
            c8dec_pkg::OP_RLC: begin
                res_nxt.acc = {i_cpu.acc[6:0], i_cpu.cy};
                res_nxt.cy = i_cpu.acc[7];
            end
            c8dec_pkg::OP_MOVC_DP, c8dec_pkg::OP_JMP_ADP:
                res_nxt.addr = 16'(i_cpu.dptr + {8'h00, i_cpu.acc});
            c8dec_pkg::OP_MOVC_PC:
                res_nxt.addr = 16'(pcn_w + {8'h00, i_cpu.acc});
            c8dec_pkg::OP_XRD_DP, c8dec_pkg::OP_XWR_DP:
                res_nxt.addr = i_cpu.dptr;
            c8dec_pkg::OP_XRD_RI: res_nxt.addr = {8'h00, i_cpu.reg_val};
            c8dec_pkg::OP_PUSH: begin
                res_nxt.sp = 8'(i_cpu.sp + 8'h01);
                res_nxt.addr = {8'h00, res_nxt.sp};
            end
            c8dec_pkg::OP_POP: begin
                res_nxt.addr = {8'h00, i_cpu.sp};
                res_nxt.sp = 8'(i_cpu.sp - 8'h01);
            end
            c8dec_pkg::OP_XCHD: begin
                res_nxt.acc = {i_cpu.acc[7:4], i_cpu.mem[3:0]};
                res_nxt.mem = {i_cpu.mem[7:4], i_cpu.acc[3:0]};
                res_nxt.addr = {8'h00, i_cpu.reg_val};
            end
            c8dec_pkg::OP_ANLC_N: res_nxt.cy = i_cpu.cy & ~i_cpu.bit_val;
            c8dec_pkg::OP_ORLC_N: res_nxt.cy = i_cpu.cy | ~i_cpu.bit_val;
            c8dec_pkg::OP_JBC: begin
                res_nxt.branch = i_cpu.bit_val;
                res_nxt.bit_clr = i_cpu.bit_val;
                res_nxt.addr = rel_f(i_cpu.pc, dec_r.len, b2_r);
            end
            c8dec_pkg::OP_CJNE_R: begin
                res_nxt.branch = i_cpu.reg_val != b1_r;
                res_nxt.cy = i_cpu.reg_val < b1_r;
                res_nxt.addr = rel_f(i_cpu.pc, dec_r.len, b2_r);
            end
            c8dec_pkg::OP_DJNZ_R: begin
                res_nxt.mem = 8'(i_cpu.reg_val - 8'h01);
                res_nxt.branch = res_nxt.mem != 8'h00;
                res_nxt.addr = rel_f(i_cpu.pc, dec_r.len, b2_r);
            end
            c8dec_pkg::OP_AJMP, c8dec_pkg::OP_ACALL: begin
                res_nxt.branch = 1'b1;
                res_nxt.addr = {pcn_w[15:11], op_r[7:5], b1_r};
            end
            c8dec_pkg::OP_MUL: begin
                res_nxt.acc = prod_w[7:0];
                res_nxt.b = prod_w[15:8];
                res_nxt.cy = 1'b0;
                res_nxt.ov = prod_w[15:8] != 8'h00;
            end
            c8dec_pkg::OP_DIV: begin
                res_nxt.cy = 1'b0;
                res_nxt.ov = i_cpu.b == 8'h00;
                if (i_cpu.b != 8'h00) begin
                    res_nxt.acc = i_cpu.acc / i_cpu.b;
                    res_nxt.b = i_cpu.acc % i_cpu.b;
                end
            end
            c8dec_pkg::OP_MOVC_ST: begin
                res_nxt.addr = i_cpu.dptr;
                res_nxt.mem = i_cpu.acc;
                res_nxt.dptr = 16'(i_cpu.dptr + 16'h1);
            end
            default: res_nxt.addr = c8dec_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_r <= '0;
        end else if (start_r) begin
            res_r <= res_nxt;
        end
    end

    // ------------------------------------------------------------
    // machine cycle timer
    // ------------------------------------------------------------
    c8dec_mc_timer #(
        .MAX_MCYC(4)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(start_r),
        .i_mcyc(dec_r.mcyc),
        .o_busy(tmr_busy_w),
        .o_done(tmr_done_w)
    );

    assign o_dec = dec_r;
    assign o_opnd1 = b1_r;
    assign o_opnd2 = b2_r;
    assign o_exec_start = start_r;
    assign o_busy = tmr_busy_w || start_r;
    assign o_done = tmr_done_w;
    assign o_res = res_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_one_mcyc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.mcyc == c8dec_pkg::MC_1
        |-> !o_done [*2] ##1 o_done)
        else $error("one machine cycle not two clocks");
    chk_two_mcyc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.mcyc == c8dec_pkg::MC_2
        |-> !o_done [*4] ##1 o_done)
        else $error("two machine cycles not four clocks");
    chk_four_mcyc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.mcyc == c8dec_pkg::MC_4
        |-> !o_done [*8] ##1 o_done)
        else $error("four machine cycles not eight clocks");
    chk_three_bytes: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        take_w && st_r == ST_IDLE && dec_w.len == c8dec_pkg::LEN_3
        |=> o_code_ready && !start_r)
        else $error("three byte opcode left fetch early");
    chk_reg_pick: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        take_w && st_r == ST_IDLE && i_code_byte[7:3] == 5'h1D
        |=> dec_r.rn == $past(i_code_byte[2:0]))
        else $error("register select not from opcode");
    chk_rlc_rot: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.op == c8dec_pkg::OP_RLC
        |=> o_res.cy == $past(i_cpu.acc[7])
            && o_res.acc[0] == $past(i_cpu.cy))
        else $error("rotate through carry wrong");
    chk_ajmp_page: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.op == c8dec_pkg::OP_AJMP
        |=> o_res.addr[10:0] == {$past(op_r[7:5]), $past(b1_r)})
        else $error("absolute jump address wrong");
    chk_div_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.op == c8dec_pkg::OP_DIV && i_cpu.b == 8'h00
        |=> o_res.ov)
        else $error("divide by zero without overflow");
    chk_xchd_keep: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.op == c8dec_pkg::OP_XCHD
        |=> o_res.acc[7:4] == $past(i_cpu.acc[7:4])
            && o_res.mem[3:0] == $past(i_cpu.acc[3:0]))
        else $error("nibble exchange wrong");
    chk_dptr_inc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        start_r && dec_r.op == c8dec_pkg::OP_INC_DP
        |=> o_res.dptr == 16'($past(i_cpu.dptr) + 16'h1))
        else $error("data pointer not incremented");
endmodule
`default_nettype wire

//--- tb/c8dec_code_mem.sv
`timescale 1ns/100ps
`default_nettype none
module c8dec_code_mem (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ready,
    input wire logic i_stall,
    output logic o_valid,
    output logic [7:0] o_byte
);
    // ------------------------------------------------------------
    // code byte source
    // ------------------------------------------------------------
    logic [7:0] q[$];
    logic took;

    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
        took = 1'b0;
    end

    always @(posedge i_clk) begin
        took <= o_valid && i_ready && i_rst_n;
    end

    // offer held until taken; stalls only between bytes
    always @(negedge i_clk) begin
        if (took)
            q.delete(0);
        if (q.size() > 0 && ((o_valid && !took) || !i_stall)) begin
            o_valid = 1'b1;
            o_byte = q[0];
        end else if (o_valid) begin
            o_valid = 1'b0;
            // released lane inverts so a stale byte cannot pass
            o_byte = ~o_byte;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic stall = 1'b0;
    logic [3:0] sel = 4'h0;
    logic vld, rdy, start, busy, done;
    logic [7:0] byte_w, o1, o2;
    c8dec_pkg::c8dec_cpu_t c = '0;
    c8dec_pkg::c8dec_dec_t d;
    c8dec_pkg::c8dec_res_t r;
    integer seed = 32'h6C54B4F6;
    int mismatches = 0;
    int n_checks = 0;
    // opcode, op code point, length, machine cycles
    logic [23:0] tbl [36] = '{
        24'h380111, 24'h3F0111, 24'h980211, 24'h9F0211, 24'hA30312,
        24'h530432, 24'h330511, 24'h930612, 24'h830712, 24'hE00812,
        24'hF00912, 24'hE20A12, 24'hE30A12, 24'hC00B22, 24'hD00C22,
        24'hD60D11, 24'hD70D11, 24'hB00E22, 24'hA00F22, 24'h101032,
        24'h731112, 24'hB81232, 24'hBD1232, 24'hD81332, 24'hDF1332,
        24'h011422, 24'hE11422, 24'h111522, 24'hF11522, 24'hA41614,
        24'h841714, 24'hA51812, 24'hA51911, 24'hE80011, 24'h000011,
        24'h850032};

    // ------------------------------------------------------------
    // clock, parts
    // ------------------------------------------------------------
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    c8dec_decoder dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_code_valid(vld), .i_code_byte(byte_w),
        .i_ext_opcode_sel(sel), .i_cpu(c), .o_code_ready(rdy),
        .o_dec(d), .o_opnd1(o1), .o_opnd2(o2), .o_exec_start(start),
        .o_busy(busy), .o_done(done), .o_res(r));

    c8dec_code_mem pm_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ready(rdy), .i_stall(stall), .o_valid(vld), .o_byte(byte_w));

    always @(negedge i_clk) begin
        stall <= 1'($random(seed));
    end

    task ck(input string w, input logic [17:0] e, input logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // one instruction against the reference
    // ------------------------------------------------------------
    task run(input logic [23:0] t, input logic p);
        logic [95:0] rv;
        logic [7:0] b1, b2;
        logic [15:0] w;
        int n;
        rv = {$random(seed), $random(seed), $random(seed)};
        c = rv[73:0];
        b1 = rv[95:88];
        b2 = rv[87:80];
        if (p && t[12:8] == 5'h17)
            c.b = 8'h00;
        sel = (t[12:8] == 5'h18) ? 4'h0 : (rv[79:76] | 4'h1);
        pm_u.q.push_back(t[23:16]);
        if (t[7:4] > 4'h1)
            pm_u.q.push_back(b1);
        if (t[7:4] > 4'h2)
            pm_u.q.push_back(b2);
        n = 0;
        while (start !== 1'b1 && n < 60) begin
            @(negedge i_clk);
            n++;
        end
        ck("ready", 18'h0, rdy);
        ck("len", t[7:4], d.len);
        ck("mcyc", t[3:0], d.mcyc);
        ck("op", t[12:8], d.op);
        if (t[7:4] > 4'h1)
            ck("opnd1", b1, o1);
        if (t[7:4] > 4'h2)
            ck("opnd2", b2, o2);
        if (t[12:8] inside {5'h1, 5'h2, 5'h12, 5'h13} || t[23:16] == 8'hE8)
            ck("rn", t[18:16], d.rn);
        if (t[12:8] inside {5'hA, 5'hD})
            ck("ri", t[16], d.ri);
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        ck("cycles", {t[3:0], 1'b0}, 18'(n));
        ck("busy", 18'h1, busy);
        w = c.pc + 16'h0002;
        case (t[12:8])
            1: ck("addc", {1'b0, c.acc} + c.reg_val + c.cy,
                {r.cy, r.acc});
            2: ck("subb", {{1'b0, c.acc} - c.reg_val - c.cy},
                {r.cy, r.acc});
            3: ck("incdp", {c.dptr + 16'h0001}, r.dptr);
            4: ck("anl", c.mem & b2, r.mem);
            5: ck("rlc", {c.acc, c.cy}, {r.cy, r.acc});
            6, 17: ck("adp", {c.acc + c.dptr}, r.addr);
            7: ck("apc", {c.acc + c.pc + 16'h0001}, r.addr);
            8, 9: ck("xdp", c.dptr, r.addr);
            10: ck("xri", c.reg_val, r.addr);
            11: ck("push", {c.sp + 8'h01}, r.sp);
            12: ck("pop", {c.sp - 8'h01}, r.sp);
            13: ck("xchd", {c.acc[7:4], c.mem[3:0], c.mem[7:4],
                c.acc[3:0]}, {r.acc, r.mem});
            14: ck("anlc", {c.cy & ~c.bit_val}, r.cy);
            15: ck("orlc", {c.cy | ~c.bit_val}, r.cy);
            16: ck("jbc", {c.bit_val, c.bit_val},
                {r.branch, r.bit_clr});
            18: ck("cjne", {c.reg_val != b1, c.reg_val < b1},
                {r.branch, r.cy});
            19: ck("djnz", {c.reg_val != 8'h01, c.reg_val - 8'h01},
                {r.branch, r.mem});
            20, 21: ck("abs", {w[15:11], t[23:21], b1}, r.addr);
            22: ck("mul", {16'(c.acc) * c.b > 16'h00FF,
                16'(c.acc) * c.b}, {r.ov, r.b, r.acc});
            23: ck("div", (c.b == 8'h00) ? {1'b1, c.acc, c.b} :
                {1'b0, c.acc / c.b, c.acc % c.b}, {r.ov, r.acc, r.b});
            24: ck("movst", {c.dptr + 16'h0001}, r.dptr);
            default: ;
        endcase
        // three byte branches land at pc plus length plus signed offset
        if (t[12:8] inside {5'h10, 5'h12, 5'h13})
            ck("rel", 16'(c.pc + 16'h0003 + {{8{b2[7]}}, b2}),
                r.addr);
        $display("test %h done", t[23:16]);
        @(negedge i_clk);
    endtask

    initial begin
        repeat (20) @(negedge i_clk);
        ck("rst ready", 18'h1, rdy);
        ck("rst start", 18'h0, start);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        // second pass forces a zero divisor
        for (int p = 0; p < 2; p++) begin
            foreach (tbl[i]) begin
                run(tbl[i], p[0]);
            end
        end
        print_verdict();
    end

    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
